/* rtl/tos_timer.sv */
// one-shot 16-bit timer with AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tos_timer (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             timerOut,
   output logic             irq
);
   typedef struct packed {
      tos_pkg::tos_ctrl_s ctrl;
      logic [15:0]        count;
      logic [15:0]        reload;
      logic               irqStat;
      logic               irqEn;
      logic               restart;
      logic               pulse;
      logic               timerOut;
      logic               irq;
      logic               awHeld;
      logic [7:0]         awAddr;
      logic               wHeld;
      logic [31:0]        wData;
      logic [3:0]         wStrb;
      logic               bValid;
      logic [1:0]         bResp;
      logic               rValid;
      logic [31:0]        rData;
      logic [1:0]         rResp;
      logic               awReady;
      logic               wReady;
      logic               arReady;
   } tos_state_s;

   tos_state_s stateFf;
   tos_state_s nxtState;
   logic       tick;
   logic       hit;
   logic       doWrite;
   logic [31:0] mergeW;
   logic [31:0] ctrlWord;

   function automatic logic known(input logic [7:0] a);
      known = (a == tos_pkg::ADDR_CTRL) || (a == tos_pkg::ADDR_COUNT) ||
              (a == tos_pkg::ADDR_RELOAD) || (a == tos_pkg::ADDR_IRQ_STAT) ||
              (a == tos_pkg::ADDR_IRQ_EN) || (a == tos_pkg::ADDR_IRQ_CLR);
   endfunction : known

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      merge = m;
   endfunction : merge

   tos_prescaler u_pre (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .restart  (stateFf.restart),
      .run      (stateFf.ctrl.enable),
      .prescale (stateFf.ctrl.prescale),
      .tick     (tick)
   );

   // match on the tick that brings the count to reload; 0000H needs the full wrap
   assign hit = stateFf.ctrl.enable && tick &&
                (16'(stateFf.count + 16'h0001) == stateFf.reload);
   assign ctrlWord = {24'h000000, 1'b0, stateFf.ctrl.prescale, 1'b0,
                      stateFf.ctrl.pinEnable, stateFf.ctrl.outputPolarityBit,
                      stateFf.ctrl.enable};
   assign doWrite = stateFf.awHeld && stateFf.wHeld && !stateFf.bValid;

   always_comb begin
      nxtState = stateFf;
      nxtState.restart = 1'b0;
      nxtState.pulse   = 1'b0;
      mergeW = 32'h00000000;

      // counting, driven only by the prescaled system clock
      if (hit) begin
         nxtState.count       = tos_pkg::COUNT_RELOAD;
         nxtState.ctrl.enable = 1'b0;
         nxtState.pulse       = 1'b1;
      end else if (stateFf.ctrl.enable && tick) begin
         nxtState.count = 16'(stateFf.count + 16'h0001);
      end

      // address and data channels
      if (s_axi_awvalid && stateFf.awReady) begin
         nxtState.awHeld = 1'b1;
         nxtState.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && stateFf.wReady) begin
         nxtState.wHeld = 1'b1;
         nxtState.wData = s_axi_wdata;
         nxtState.wStrb = s_axi_wstrb;
      end

      if (doWrite) begin
         nxtState.awHeld = 1'b0;
         nxtState.wHeld  = 1'b0;
         nxtState.bValid = 1'b1;
         nxtState.bResp  = known(stateFf.awAddr) ? tos_pkg::RESP_OKAY : tos_pkg::RESP_SLVERR;
         case (stateFf.awAddr)
            tos_pkg::ADDR_CTRL: begin
               mergeW = merge(ctrlWord, stateFf.wData, stateFf.wStrb);
               nxtState.ctrl.enable            = mergeW[tos_pkg::CTRL_EN_BIT];
               nxtState.ctrl.outputPolarityBit = mergeW[tos_pkg::CTRL_POL_BIT];
               nxtState.ctrl.pinEnable         = mergeW[tos_pkg::CTRL_OE_BIT];
               nxtState.ctrl.prescale          = mergeW[tos_pkg::CTRL_PRE_LSB +: 3];
               nxtState.restart = mergeW[tos_pkg::CTRL_EN_BIT];
            end
            tos_pkg::ADDR_COUNT: begin
               mergeW = merge({16'h0000, nxtState.count}, stateFf.wData, stateFf.wStrb);
               nxtState.count = mergeW[15:0];
            end
            tos_pkg::ADDR_RELOAD: begin
               mergeW = merge({16'h0000, stateFf.reload}, stateFf.wData, stateFf.wStrb);
               nxtState.reload = mergeW[15:0];
            end
            tos_pkg::ADDR_IRQ_EN: begin
               if (stateFf.wStrb[0]) begin
                  nxtState.irqEn = stateFf.wData[0];
               end
            end
            tos_pkg::ADDR_IRQ_CLR: begin
               if (stateFf.wStrb[0] && stateFf.wData[0]) begin
                  nxtState.irqStat = 1'b0;
               end
            end
            default: begin
               nxtState.bValid = 1'b1;
            end
         endcase
      end
      if (stateFf.bValid && s_axi_bready) begin
         nxtState.bValid = 1'b0;
      end

      // set wins over a same-cycle clear
      if (hit) begin
         nxtState.irqStat = 1'b1;
      end

      // read channel
      if (s_axi_arvalid && stateFf.arReady) begin
         nxtState.rValid = 1'b1;
         nxtState.rResp  = known(s_axi_araddr) ? tos_pkg::RESP_OKAY : tos_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            tos_pkg::ADDR_CTRL:     nxtState.rData = ctrlWord;
            tos_pkg::ADDR_COUNT:    nxtState.rData = {16'h0000, stateFf.count};
            tos_pkg::ADDR_RELOAD:   nxtState.rData = {16'h0000, stateFf.reload};
            tos_pkg::ADDR_IRQ_STAT: nxtState.rData = {31'h00000000, stateFf.irqStat};
            tos_pkg::ADDR_IRQ_EN:   nxtState.rData = {31'h00000000, stateFf.irqEn};
            default:                nxtState.rData = 32'h00000000;
         endcase
      end else if (stateFf.rValid && s_axi_rready) begin
         nxtState.rValid = 1'b0;
      end

      // output: polarity level, inverted for one clock at the reload event
      nxtState.timerOut = nxtState.ctrl.outputPolarityBit ^
                          (nxtState.pulse & nxtState.ctrl.pinEnable);
      nxtState.irq = nxtState.irqStat & nxtState.irqEn;
      nxtState.awReady = !nxtState.awHeld;
      nxtState.wReady  = !nxtState.wHeld;
      nxtState.arReady = !nxtState.rValid;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stateFf        <= '0;
         stateFf.count  <= tos_pkg::COUNT_RESET;
         stateFf.reload <= tos_pkg::RELOAD_RESET;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign s_axi_awready = stateFf.awReady;
   assign s_axi_wready  = stateFf.wReady;
   assign s_axi_bvalid  = stateFf.bValid;
   assign s_axi_bresp   = stateFf.bResp;
   assign s_axi_arready = stateFf.arReady;
   assign s_axi_rvalid  = stateFf.rValid;
   assign s_axi_rdata   = stateFf.rData;
   assign s_axi_rresp   = stateFf.rResp;
   assign timerOut      = stateFf.timerOut;
   assign irq           = stateFf.irq;

   sequence s_hit;
      hit && !doWrite;
   endsequence

   sequence s_stopped;
      !stateFf.ctrl.enable && stateFf.count == tos_pkg::COUNT_RELOAD;
   endsequence

   sequence s_wr_pending;
      stateFf.awHeld && stateFf.wHeld && !stateFf.bValid;
   endsequence

   sequence s_b_issued;
      s_axi_bvalid && s_axi_awready && s_axi_wready;
   endsequence

   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_hit_reloads: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_hit |=> s_stopped)
      else $error("count did not reload to one after match");

   a_hit_stops: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_hit |=> !stateFf.ctrl.enable ##1 (stateFf.count == tos_pkg::COUNT_RELOAD || doWrite ||
      $past(doWrite)))
      else $error("timer kept counting after match");

   a_hit_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
      hit |=> stateFf.irqStat)
      else $error("status not set on match");

   a_count_step: assert property (@(posedge ref_clk) disable iff (!resetn)
      (stateFf.ctrl.enable && tick && !hit && !doWrite) |=>
      stateFf.count == 16'($past(stateFf.count) + 16'h0001))
      else $error("count did not advance by one");

   a_count_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      (stateFf.ctrl.enable && tick && !hit && !doWrite && stateFf.count == 16'hFFFF) |=>
      stateFf.count == 16'h0000)
      else $error("count did not wrap to zero");

   a_count_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!tick && !doWrite) |=> $stable(stateFf.count))
      else $error("count moved without a tick");

   a_out_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      (hit && stateFf.ctrl.pinEnable && !doWrite) |=>
      timerOut != stateFf.ctrl.outputPolarityBit ##1
      (timerOut == stateFf.ctrl.outputPolarityBit || doWrite))
      else $error("output pulse not one clock wide");

   a_out_level: assert property (@(posedge ref_clk) disable iff (!resetn)
      !stateFf.pulse |-> timerOut == stateFf.ctrl.outputPolarityBit)
      else $error("output not at polarity level");

   a_fast_timeout: assert property (@(posedge ref_clk) disable iff (!resetn)
      (stateFf.restart && stateFf.ctrl.prescale == 3'h0 &&
      stateFf.reload == 16'h0001 && stateFf.count == 16'h0000) |=> ##1 hit)
      else $error("shortest time-out not two cycles");

   a_pulse_single: assert property (@(posedge ref_clk) disable iff (!resetn)
      stateFf.pulse |=> !stateFf.pulse)
      else $error("reload pulse longer than one clock");

   a_idle_no_tick: assert property (@(posedge ref_clk) disable iff (!resetn)
      !stateFf.ctrl.enable |=> !tick)
      else $error("prescaler ticked while disabled");

   a_restart_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
      stateFf.restart |=> !tick)
      else $error("prescaler ticked right after restart");

   a_ctrl_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      (doWrite && stateFf.awAddr == tos_pkg::ADDR_CTRL && stateFf.wStrb[0]) |=>
      stateFf.ctrl.enable == $past(stateFf.wData[tos_pkg::CTRL_EN_BIT]))
      else $error("control write did not set enable");

   a_start_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
      (doWrite && stateFf.awAddr == tos_pkg::ADDR_CTRL && stateFf.wStrb[0] &&
      stateFf.wData[tos_pkg::CTRL_EN_BIT]) |=> stateFf.restart)
      else $error("enabling write did not restart prescaler");

   a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
      irq == (stateFf.irqStat && stateFf.irqEn))
      else $error("interrupt not equal to enabled status");

   a_stat_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
      (stateFf.irqStat && !doWrite) |=> stateFf.irqStat)
      else $error("status cleared without a write");

   a_irq_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      (doWrite && stateFf.awAddr == tos_pkg::ADDR_IRQ_CLR && stateFf.wStrb[0] &&
      stateFf.wData[0] && !hit) |=> !stateFf.irqStat)
      else $error("status not cleared by clear write");

   a_reload_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !doWrite |=> $stable(stateFf.reload))
      else $error("reload changed without a write");

   a_wr_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_wr_pending |=> s_b_issued)
      else $error("write response not issued");

   a_wr_okay: assert property (@(posedge ref_clk) disable iff (!resetn)
      (doWrite && known(stateFf.awAddr)) |=> s_axi_bresp == tos_pkg::RESP_OKAY)
      else $error("mapped write not answered okay");

   a_wr_slverr: assert property (@(posedge ref_clk) disable iff (!resetn)
      (doWrite && !known(stateFf.awAddr)) |=> s_axi_bresp == tos_pkg::RESP_SLVERR)
      else $error("unmapped write not answered with error");

   a_rd_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not returned");

   a_rd_slverr: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready && !known(s_axi_araddr)) |=>
      s_axi_rresp == tos_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not answered with error");

   a_b_stands: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   a_r_stands: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_axi_rvalid && !s_axi_rready) |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before taken");

   a_b_release: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
      else $error("write response held after taken");

   a_r_release: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
      else $error("read data held after taken");
endmodule : tos_timer

/* rtl/tos_pkg.sv */
// package of constants and carrier types for the one-shot timer
package tos_pkg;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_COUNT    = 8'h04;
   localparam logic [7:0]  ADDR_RELOAD   = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0]  ADDR_IRQ_EN   = 8'h10;
   localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h14;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_POL_BIT  = 1;
   localparam int          CTRL_OE_BIT   = 2;
   localparam int          CTRL_PRE_LSB  = 4;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_RELOAD  = 16'h0001;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [2:0] prescale;
      logic       pinEnable;
      logic       outputPolarityBit;
      logic       enable;
   } tos_ctrl_s;

   typedef struct packed {
      logic        tick;
      logic [15:0] count;
   } tos_tick_s;
endpackage : tos_pkg

/* rtl/tos_prescaler.sv */
// prescaler producing one tick per 2^n system clocks
`timescale 1ns/100ps
module tos_prescaler (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       restart,
   input  wire logic       run,
   input  wire logic [2:0] prescale,
   output logic            tick
);
   typedef struct packed {
      logic [6:0] div;
      logic       tick;
   } tos_pre_state_s;

   tos_pre_state_s stateFf;
   tos_pre_state_s nxtState;
   logic [6:0]     limit;

   always_comb begin
      limit    = 7'((8'h01 << prescale) - 8'h01);
      nxtState = stateFf;
      nxtState.tick = 1'b0;
      if (restart || !run) begin
         nxtState.div = 7'h00;
      end else if (stateFf.div == limit) begin
         nxtState.div  = 7'h00;
         nxtState.tick = 1'b1;
      end else begin
         nxtState.div = 7'(stateFf.div + 7'h01);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stateFf <= '0;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign tick = stateFf.tick;

   a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!resetn)
      (tick && prescale == 3'h1 && run && !restart) |=> !tick)
      else $error("prescaler ticked on consecutive cycles at divide by two");
endmodule : tos_prescaler

/* dv/tos_timer_bench.sv */
// self-checking bench for the one-shot timer over its register bus
`timescale 1ns/100ps
module tos_timer_bench;
   logic        ref_clk;
   logic        resetn;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        timerOut;
   logic        irq;
   logic [3:0]  strb;
   int          failCount;
   int          numChecks;

   tos_timer dut (.ref_clk(ref_clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .timerOut(timerOut), .irq(irq));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask : check_bit

   // address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge ref_clk);
         if (!awDone && s_axi_awready === 1'b1) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready === 1'b1) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      check_word({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
      check_word(s_axi_rdata, exp);
      check_word({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask : rd

   // one complete single-shot run, timed at the output pin
   task automatic shot(input logic [2:0] pre, input logic [15:0] st, input logic [15:0] rl,
                       input logic pol, input logic ie);
      logic [31:0] c;
      int          want;
      int          n;
      c = {25'h0, pre, 1'b0, 1'b1, pol, 1'b0};
      want = int'(16'(rl - st)) << pre;
      n = 0;
      wr(tos_pkg::ADDR_CTRL, c, tos_pkg::RESP_OKAY);
      check_bit(timerOut, pol);
      wr(tos_pkg::ADDR_COUNT, {16'h0, st}, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_RELOAD, {16'h0, rl}, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_IRQ_EN, {31'h0, ie}, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_CTRL, c | 32'h1, tos_pkg::RESP_OKAY);
      while (timerOut === pol && n < 40000) begin
         @(posedge ref_clk);
         n++;
      end
      check_bit(n >= want - 2 && n <= want + 4, 1'b1);
      @(posedge ref_clk);
      check_bit(timerOut, pol);
      @(posedge ref_clk);
      check_bit(irq, ie);
      rd(tos_pkg::ADDR_COUNT, 32'h1, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_IRQ_STAT, 32'h1, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_CTRL, c, tos_pkg::RESP_OKAY);
      repeat (260) @(posedge ref_clk);
      rd(tos_pkg::ADDR_COUNT, 32'h1, tos_pkg::RESP_OKAY);
      if (!ie) begin
         wr(tos_pkg::ADDR_IRQ_EN, 32'h1, tos_pkg::RESP_OKAY);
         @(posedge ref_clk);
         check_bit(irq, 1'b1);
      end
      wr(tos_pkg::ADDR_IRQ_CLR, 32'h1, tos_pkg::RESP_OKAY);
      @(posedge ref_clk);
      check_bit(irq, 1'b0);
      rd(tos_pkg::ADDR_IRQ_STAT, 32'h0, tos_pkg::RESP_OKAY);
   endtask : shot

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (30000) @(posedge ref_clk);
      failCount++;
      stop_test();
   end

   initial begin
      failCount = 0;
      numChecks = 0;
      strb = 4'hF;
      resetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      check_bit(irq, 1'b0);
      check_bit(timerOut, 1'b0);
      rd(tos_pkg::ADDR_CTRL, 32'h0, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_COUNT, 32'h0, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_RELOAD, 32'h0, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_IRQ_STAT, 32'h0, tos_pkg::RESP_OKAY);
      rd(tos_pkg::ADDR_IRQ_CLR, 32'h0, tos_pkg::RESP_OKAY);
      $display("test reset values done");
      wr(8'h18, 32'h5, tos_pkg::RESP_SLVERR);
      rd(8'h18, 32'h0, tos_pkg::RESP_SLVERR);
      wr(tos_pkg::ADDR_RELOAD, 32'h1234, tos_pkg::RESP_OKAY);
      strb = 4'h1;
      wr(tos_pkg::ADDR_RELOAD, 32'hFFFF, tos_pkg::RESP_OKAY);
      strb = 4'hF;
      rd(tos_pkg::ADDR_RELOAD, 32'h12FF, tos_pkg::RESP_OKAY);
      $display("test bus errors and strobes done");
      shot(3'h0, 16'h0000, 16'h0001, 1'b0, 1'b1);
      shot(3'h3, 16'h000A, 16'h000E, 1'b1, 1'b0);
      shot(3'h7, 16'h0000, 16'h0002, 1'b0, 1'b1);
      shot(3'h0, 16'hFFFE, 16'h0001, 1'b1, 1'b1);
      shot(3'h0, 16'hFFFF, 16'h0000, 1'b0, 1'b0);
      wr(tos_pkg::ADDR_CTRL, 32'h74, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_COUNT, 32'h0, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_RELOAD, 32'h2, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_CTRL, 32'h75, tos_pkg::RESP_OKAY);
      wr(tos_pkg::ADDR_CTRL, 32'h77, tos_pkg::RESP_OKAY);
      check_bit(timerOut, 1'b1);
      repeat (600) @(posedge ref_clk);
      check_bit(timerOut, 1'b1);
      rd(tos_pkg::ADDR_CTRL, 32'h76, tos_pkg::RESP_OKAY);
      $display("test single shots done");
      stop_test();
   end
endmodule : tos_timer_bench
